// [src/tmc_pkg.sv]
// Shared constants and carrier types for the dual timer/counter block
package tmc_pkg;

    // Register byte addresses on the Avalon-MM slave
    localparam int TMC_ADDR_W = 8;
    localparam int TMC_DATA_W = 32;
    localparam logic [7:0] TMC_ADDR_CTRL = 8'h88;
    localparam logic [7:0] TMC_ADDR_MODE = 8'h8C;
    localparam logic [7:0] TMC_ADDR_T0_LO = 8'h90;
    localparam logic [7:0] TMC_ADDR_T0_HI = 8'h94;
    localparam logic [7:0] TMC_ADDR_T1_LO = 8'h98;
    localparam logic [7:0] TMC_ADDR_T1_HI = 8'h9C;

    // Control register bit positions
    localparam int TMC_CTRL_TF1 = 7;
    localparam int TMC_CTRL_TR1 = 6;
    localparam int TMC_CTRL_TF0 = 5;
    localparam int TMC_CTRL_TR0 = 4;

    // Reset values and the all-ones byte
    localparam logic [7:0] TMC_CTRL_RST = 8'h00;
    localparam logic [7:0] TMC_MODE_RST = 8'h00;
    localparam logic [7:0] TMC_BYTE_RST = 8'h00;
    localparam logic [7:0] TMC_BYTE_ONES = 8'hFF;

    // Mode field encodings
    localparam logic [1:0] TMC_MODE_13BIT = 2'h0;
    localparam logic [1:0] TMC_MODE_16BIT = 2'h1;
    localparam logic [1:0] TMC_MODE_RELOAD = 2'h2;
    localparam logic [1:0] TMC_MODE_SPLIT = 2'h3;

    // Prescale width in 13-bit mode and machine cycle length
    localparam int TMC_PRE_BITS = 5;
    localparam logic [4:0] TMC_PRE_ONES = 5'h1F;
    localparam int TMC_MC_CLOCKS = 6;

    // One timer's count bytes
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } tmc_count_t;

    // Mode setup register layout, bit 7 down to bit 0
    typedef struct packed {
        logic [1:0] rsvd;
        logic [1:0] t1_mode;
        logic gate;
        logic ct;
        logic [1:0] t0_mode;
    } tmc_mode_t;

endpackage

// [src/tmc_count_step.sv]
// Next-count computation for one timer in modes 0, 1, 2 and low-byte split
`timescale 1ns/1ps
module tmc_count_step
    import tmc_pkg::*;
(
    input wire logic [1:0] mode_i,
    input wire logic inc_i,
    input wire tmc_count_t cnt_i,
    output tmc_count_t cnt_o,
    output logic ovf_o
);

    logic [12:0] c13;
    logic [15:0] c16;

    // Count chains per mode
    always_comb begin
        c13 = {cnt_i.hi, cnt_i.lo[TMC_PRE_BITS-1:0]} + 13'h0001;
        c16 = {cnt_i.hi, cnt_i.lo} + 16'h0001;
        cnt_o = cnt_i;
        ovf_o = 1'b0;
        if (inc_i) begin
            case (mode_i)
                TMC_MODE_13BIT: begin
                    // Upper three low bits left untouched
                    cnt_o.hi = c13[12:TMC_PRE_BITS];
                    cnt_o.lo[TMC_PRE_BITS-1:0] = c13[TMC_PRE_BITS-1:0];
                    ovf_o = (cnt_i.hi == TMC_BYTE_ONES) &&
                        (cnt_i.lo[TMC_PRE_BITS-1:0] == TMC_PRE_ONES);
                end
                TMC_MODE_16BIT: begin
                    cnt_o = c16;
                    ovf_o = ({cnt_i.hi, cnt_i.lo} == {TMC_BYTE_ONES, TMC_BYTE_ONES});
                end
                TMC_MODE_RELOAD: begin
                    ovf_o = (cnt_i.lo == TMC_BYTE_ONES);
                    cnt_o.lo = ovf_o ? cnt_i.hi : c16[7:0];
                end
                default: begin
                    cnt_o.lo = c16[7:0];
                    ovf_o = (cnt_i.lo == TMC_BYTE_ONES);
                end
            endcase
        end
    end

endmodule // tmc_count_step

// [src/tmc_timer_top.sv]
// Dual timer/counter with Avalon-MM register slave
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module tmc_timer_top
    import tmc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [TMC_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [TMC_DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [TMC_DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic count_pin_i,
    input wire logic external_gate_pin_i,
    input wire logic tf0_ack_i,
    input wire logic tf1_ack_i,
    output logic timer_zero_overflow_flag_o,
    output logic timer_one_overflow_flag_o,
    output logic t0_ovf_o,
    output logic t1_ovf_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic ack_q, ack_d;
    logic [TMC_DATA_W-1:0] rdata_q, rdata_d;
    logic timer_zero_run_bit_q, timer_zero_run_bit_d;
    logic timer_one_run_bit_q, timer_one_run_bit_d;
    logic tf0_q, tf0_d, tf1_q, tf1_d;
    tmc_mode_t mode_q, mode_d;
    tmc_count_t t0_q, t0_d, t1_q, t1_d;
    tmc_count_t t0_step, t1_step;
    logic t0_ovf_q, t0_ovf_d, t1_ovf_q, t1_ovf_d;
    logic [2:0] mc_cnt_q, mc_cnt_d;
    logic [2:0] cpin_s_q, cpin_s_d, gpin_s_q, gpin_s_d;
    logic cpin_lvl_q, cpin_lvl_d, gpin_lvl_q, gpin_lvl_d;
    logic samp_q, samp_d;
    logic tick, fall, split0, run0, run1;
    logic inc0, inc1, ovf0, ovf1, th0_inc, th0_ovf;
    logic bus_rd, bus_wr;
    logic [7:0] wbyte, rbyte;

    // Byte address match for one register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, then answer

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign bus_wr = avs_write_i & ack_q & avs_byteenable_i[0];
    assign bus_rd = avs_read_i & ~ack_q;
    assign wbyte = avs_writedata_i[7:0];
    assign avs_readdata_o = rdata_q;

    // Read mux; unmapped addresses read zero
    always_comb begin
        rbyte = TMC_BYTE_RST;
        if (hit(avs_address_i, TMC_ADDR_CTRL)) begin
            rbyte = TMC_CTRL_RST;
            rbyte[TMC_CTRL_TF1] = tf1_q;
            rbyte[TMC_CTRL_TR1] = timer_one_run_bit_q;
            rbyte[TMC_CTRL_TF0] = tf0_q;
            rbyte[TMC_CTRL_TR0] = timer_zero_run_bit_q;
        end else if (hit(avs_address_i, TMC_ADDR_MODE)) begin
            rbyte = mode_q;
        end else if (hit(avs_address_i, TMC_ADDR_T0_LO)) begin
            rbyte = t0_q.lo;
        end else if (hit(avs_address_i, TMC_ADDR_T0_HI)) begin
            rbyte = t0_q.hi;
        end else if (hit(avs_address_i, TMC_ADDR_T1_LO)) begin
            rbyte = t1_q.lo;
        end else if (hit(avs_address_i, TMC_ADDR_T1_HI)) begin
            rbyte = t1_q.hi;
        end
        ack_d = (avs_read_i | avs_write_i) & ~ack_q;
        rdata_d = bus_rd ? {24'h000000, rbyte} : rdata_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and machine cycle tick

    always_comb begin
        cpin_s_d = {cpin_s_q[1:0], count_pin_i};
        gpin_s_d = {gpin_s_q[1:0], external_gate_pin_i};
        // Level accepted once second and third stages agree
        cpin_lvl_d = (cpin_s_q[1] == cpin_s_q[2]) ? cpin_s_q[2] : cpin_lvl_q;
        gpin_lvl_d = (gpin_s_q[1] == gpin_s_q[2]) ? gpin_s_q[2] : gpin_lvl_q;
        tick = (mc_cnt_q == 3'(TMC_MC_CLOCKS - 1));
        mc_cnt_d = tick ? 3'h0 : mc_cnt_q + 3'h1;
        samp_d = tick ? cpin_lvl_q : samp_q;
        fall = tick & samp_q & ~cpin_lvl_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Count enables

    always_comb begin
        split0 = (mode_q.t0_mode == TMC_MODE_SPLIT);
        run0 = timer_zero_run_bit_q & (~mode_q.gate | gpin_lvl_q);
        inc0 = run0 & (mode_q.ct ? fall : tick);
        // Run bit 1 goes to the split high byte while timer 0 is split
        run1 = (mode_q.t1_mode != TMC_MODE_SPLIT) &
            (split0 | timer_one_run_bit_q);
        inc1 = tick & run1;
        th0_inc = tick & split0 & timer_one_run_bit_q;
        th0_ovf = th0_inc & (t0_q.hi == TMC_BYTE_ONES);
    end

    tmc_count_step u_step0 (
        .mode_i(mode_q.t0_mode),
        .inc_i(inc0),
        .cnt_i(t0_q),
        .cnt_o(t0_step),
        .ovf_o(ovf0)
    );

    tmc_count_step u_step1 (
        .mode_i(mode_q.t1_mode),
        .inc_i(inc1),
        .cnt_i(t1_q),
        .cnt_o(t1_step),
        .ovf_o(ovf1)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state of counts, control bits and flags

    always_comb begin
        t0_d = t0_step;
        if (split0 && th0_inc) begin
            t0_d.hi = t0_q.hi + 8'h01;
        end
        t1_d = t1_step;
        mode_d = mode_q;
        timer_zero_run_bit_d = timer_zero_run_bit_q;
        timer_one_run_bit_d = timer_one_run_bit_q;
        tf0_d = tf0_q;
        tf1_d = tf1_q;
        // Software writes win over counting; run bits leave counts
        if (bus_wr) begin
            if (hit(avs_address_i, TMC_ADDR_CTRL)) begin
                timer_zero_run_bit_d = wbyte[TMC_CTRL_TR0];
                timer_one_run_bit_d = wbyte[TMC_CTRL_TR1];
                tf0_d = wbyte[TMC_CTRL_TF0];
                tf1_d = wbyte[TMC_CTRL_TF1];
            end
            if (hit(avs_address_i, TMC_ADDR_MODE)) begin
                mode_d = tmc_mode_t'(wbyte);
                mode_d.rsvd = 2'h0;
            end
            if (hit(avs_address_i, TMC_ADDR_T0_LO)) begin
                t0_d.lo = wbyte;
            end
            if (hit(avs_address_i, TMC_ADDR_T0_HI)) begin
                t0_d.hi = wbyte;
            end
            if (hit(avs_address_i, TMC_ADDR_T1_LO)) begin
                t1_d.lo = wbyte;
            end
            if (hit(avs_address_i, TMC_ADDR_T1_HI)) begin
                t1_d.hi = wbyte;
            end
        end
        // Service acknowledge clears
        if (tf0_ack_i) begin
            tf0_d = 1'b0;
        end
        if (tf1_ack_i) begin
            tf1_d = 1'b0;
        end
        // Hardware set wins over any clear
        if (ovf0) begin
            tf0_d = 1'b1;
        end
        if (split0 ? th0_ovf : ovf1) begin
            tf1_d = 1'b1;
        end
        t0_ovf_d = ovf0;
        t1_ovf_d = ovf1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
            timer_zero_run_bit_q <= 1'b0;
            timer_one_run_bit_q <= 1'b0;
            tf0_q <= 1'b0;
            tf1_q <= 1'b0;
            mode_q <= tmc_mode_t'(TMC_MODE_RST);
            t0_q <= '0;
            t1_q <= '0;
            t0_ovf_q <= 1'b0;
            t1_ovf_q <= 1'b0;
            mc_cnt_q <= 3'h0;
            cpin_s_q <= 3'h0;
            gpin_s_q <= 3'h0;
            cpin_lvl_q <= 1'b0;
            gpin_lvl_q <= 1'b0;
            samp_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            timer_zero_run_bit_q <= timer_zero_run_bit_d;
            timer_one_run_bit_q <= timer_one_run_bit_d;
            tf0_q <= tf0_d;
            tf1_q <= tf1_d;
            mode_q <= mode_d;
            t0_q <= t0_d;
            t1_q <= t1_d;
            t0_ovf_q <= t0_ovf_d;
            t1_ovf_q <= t1_ovf_d;
            mc_cnt_q <= mc_cnt_d;
            cpin_s_q <= cpin_s_d;
            gpin_s_q <= gpin_s_d;
            cpin_lvl_q <= cpin_lvl_d;
            gpin_lvl_q <= gpin_lvl_d;
            samp_q <= samp_d;
        end
    end

    // Flag and pulse outputs
    assign timer_zero_overflow_flag_o = tf0_q;
    assign timer_one_overflow_flag_o = tf1_q;
    assign t0_ovf_o = t0_ovf_q;
    assign t1_ovf_o = t1_ovf_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_tick_gap;
        !tick [*5] ##1 tick;
    endsequence

    sequence s_bus_idle;
        !bus_wr;
    endsequence

    chk_tick_period: assert property (tick |=> s_tick_gap)
        else $error("machine tick not every six clocks");

    chk_t0_flag_set: assert property (t0_ovf_o |-> tf0_q)
        else $error("timer 0 overflow did not set flag");

    chk_t1_flag_set: assert property ((t1_ovf_o && !$past(split0)) |-> tf1_q)
        else $error("timer 1 overflow did not set flag");

    chk_t0_stopped: assert property ((!timer_zero_run_bit_q and s_bus_idle) |=>
        $stable(t0_q.lo))
        else $error("timer 0 low byte moved while stopped");

    chk_t1_mode3_halt: assert property (((mode_q.t1_mode == TMC_MODE_SPLIT) and s_bus_idle)
        |=> $stable(t1_q))
        else $error("timer 1 moved in mode 3");

    chk_reload_value: assert property ((t0_ovf_o && $past(mode_q.t0_mode) == TMC_MODE_RELOAD
        && !$past(bus_wr)) |-> (t0_q.lo == t0_q.hi))
        else $error("reload did not copy high byte");

    chk_mode0_wrap: assert property ((t0_ovf_o && $past(mode_q.t0_mode) == TMC_MODE_13BIT
        && !$past(bus_wr)) |-> (t0_q.hi == 8'h00 && t0_q.lo[4:0] == 5'h00))
        else $error("13-bit count did not wrap to zero");

    chk_split_high: assert property (((split0 && timer_one_run_bit_q && tick) and s_bus_idle)
        |=> (t0_q.hi == $past(t0_q.hi) + 8'h01))
        else $error("split high byte did not advance");

    chk_ovf_pulse: assert property (t0_ovf_o |=> !t0_ovf_o)
        else $error("overflow pulse longer than one cycle");

    chk_bus_answer: assert property (avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("waitrequest held more than one cycle");

endmodule // tmc_timer_top

// [dv/tmc_pin_model.sv]
// Model of the external count and gate pins of timer 0
`timescale 1ns/1ps
module tmc_pin_model (
    input wire logic ref_clk_i,
    input wire logic fire_i,
    input wire logic gate_lvl_i,
    output logic count_pin_o,
    output logic gate_pin_o
);
    int hold_q = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Count pin idles high; each request gives one low pulse of two machine cycles
    always @(posedge ref_clk_i) begin
        if (fire_i && hold_q == 0) begin
            hold_q <= 12;
        end else if (hold_q != 0) begin
            hold_q <= hold_q - 1;
        end
    end
    // Low only while a pulse is held
    assign count_pin_o = (hold_q == 0);
    // Gate level as the bench asks for it
    assign gate_pin_o = gate_lvl_i;
endmodule // tmc_pin_model

// [dv/tmc_timer_top_tb_top.sv]
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ps
module tmc_timer_top_tb_top
    import tmc_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdata;
    logic wait_rq;
    logic count_pin, gate_pin, f0, f1, p0, p1;
    logic fire = 1'b0;
    logic gate_lvl = 1'b0;
    logic ack0 = 1'b0;
    logic ack1 = 1'b0;
    logic [15:0] seed = 16'h0519;
    logic [7:0] q;
    int failures = 0;
    int n_checks = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and instances
    always #50 ref_clk_i = ~ref_clk_i;
    tmc_timer_top u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_rq), .count_pin_i(count_pin),
        .external_gate_pin_i(gate_pin), .tf0_ack_i(ack0), .tf1_ack_i(ack1),
        .timer_zero_overflow_flag_o(f0), .timer_one_overflow_flag_o(f1),
        .t0_ovf_o(p0), .t1_ovf_o(p1));
    tmc_pin_model u_pins (.ref_clk_i(ref_clk_i), .fire_i(fire), .gate_lvl_i(gate_lvl),
        .count_pin_o(count_pin), .gate_pin_o(gate_pin));
    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    function automatic logic [7:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction
    function automatic int rn();
        return 1 + int'(rnd() & 8'h07);
    endfunction
    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] r);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {24'h0, d};
        // Request stands until the rising edge that sees waitrequest low
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (wait_rq !== 1'b0 && n < 20);
        r = rdata[7:0];
        chk(n < 20 && rdata[31:8] === 24'h0, "bus answer");
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic wrt(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, a, d, r);
    endtask
    // Wait a bounded time for a timer 0 overflow pulse
    task automatic await0(input string m);
        int c;
        c = 0;
        do begin
            @(negedge ref_clk_i);
            c++;
        end while (p0 !== 1'b1 && c < 60);
        chk(p0 === 1'b1, m);
    endtask
    // Service pulse on one flag, then it must read clear
    task automatic ackp(input bit t);
        @(posedge ref_clk_i);
        ack0 <= !t;
        ack1 <= t;
        @(posedge ref_clk_i);
        ack0 <= 1'b0;
        ack1 <= 1'b0;
        @(negedge ref_clk_i);
        chk((t ? f1 : f0) === 1'b0, "flag not cleared by service");
    endtask
    // Load a count n ticks short of overflow, start, time the overflow, check the bytes
    // sel 0 watches timer 0 pulse, 1 timer 1 pulse, 2 timer 1 flag; n 0 expects silence
    task automatic run(input logic [7:0] md, input logic [7:0] ctl, input int sel, input int n);
        logic [7:0] lo, hi, r, ab, fm;
        logic [1:0] m;
        logic sig;
        int c, lim, nn;
        nn = (n == 0) ? 1 : n;
        m = (sel == 1) ? md[5:4] : md[1:0];
        ab = (sel == 1) ? 8'h98 : 8'h90;
        fm = (sel == 0) ? 8'h20 : 8'h80;
        hi = rnd();
        lo = rnd();
        case (m)
            2'h0: {hi, lo[4:0]} = 13'(8192 - nn);
            2'h1: {hi, lo} = 16'(65536 - nn);
            default: lo = 8'(256 - nn);
        endcase
        if (sel == 2) hi = 8'(256 - nn);
        wrt(8'h88, 8'h00);
        // Timer 1 parked in mode 3 while its counts are loaded
        wrt(8'h8C, md | 8'h30);
        wrt(ab, lo);
        wrt(ab + 8'h04, hi);
        // Timer 1 with timer 0 split starts by leaving mode 3, so that write goes last
        if (sel == 1 && !ctl[6]) wrt(8'h88, ctl);
        wrt(8'h8C, md);
        if (!(sel == 1 && !ctl[6])) wrt(8'h88, ctl);
        lim = (n == 0) ? 60 : 6 * n + 2;
        c = 0;
        do begin
            @(negedge ref_clk_i);
            c++;
            sig = (sel == 0) ? p0 : (sel == 1) ? p1 : f1;
        end while (sig !== 1'b1 && c < lim);
        if (n == 0) begin
            chk(sig === 1'b0, "counted while held off");
            return;
        end
        chk(sig === 1'b1 && c >= 6 * n - 6, "overflow time");
        if (sel == 0) chk(f0 === 1'b1, "flag not set");
        if (sel < 2) begin
            @(negedge ref_clk_i);
            chk(((sel == 0) ? p0 : p1) === 1'b0, "pulse too long");
        end
        if (sel == 1 && !ctl[6]) return;
        wrt(8'h88, fm);
        bus(1'b0, 8'h88, 8'h00, r);
        chk(r === fm, "control readback");
        if (sel == 2) return;
        bus(1'b0, ab, 8'h00, r);
        chk(m == 0 ? r[4:0] === 5'h0 : r === (m == 2 ? hi : 8'h00), "low byte");
        bus(1'b0, ab + 8'h04, 8'h00, r);
        chk(r === (m[1] ? hi : 8'h00), "high byte");
    endtask
    // Verdict
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #2000000;
        failures++;
        results();
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 8'h88 + 8'(i * 4), 8'h00, q);
            chk(q === 8'h00, "reset value");
        end
        wrt(8'h80, 8'h5A);
        bus(1'b0, 8'h80, 8'h00, q);
        chk(q === 8'h00, "unmapped read");
        @(posedge ref_clk_i);
        be <= 4'h0;
        wrt(8'h90, 8'hA5);
        @(posedge ref_clk_i);
        be <= 4'hF;
        bus(1'b0, 8'h90, 8'h00, q);
        chk(q === 8'h00, "write without byte enable");
        for (int k = 0; k < 2; k++) begin
            for (int m = 0; m < 3; m++) begin
                run(8'(m), 8'h10, 0, rn());
                run(8'(m * 16), 8'h40, 1, rn());
            end
        end
        ackp(1'b1);
        run(8'h03, 8'h10, 0, rn());
        ackp(1'b0);
        run(8'h03, 8'h40, 2, rn());
        run(8'h13, 8'h00, 1, rn());
        run(8'h30, 8'h40, 1, 0);
        run(8'h01, 8'h00, 0, 0);
        run(8'h09, 8'h10, 0, 0);
        @(posedge ref_clk_i);
        gate_lvl <= 1'b1;
        await0("gate did not open");
        run(8'h05, 8'h10, 0, 0);
        @(posedge ref_clk_i);
        fire <= 1'b1;
        @(posedge ref_clk_i);
        fire <= 1'b0;
        await0("falling edge not counted");
        results();
    end
endmodule // tmc_timer_top_tb_top
